/* hdl/wdg_pkg.sv */
// Purpose: shared constants and carriers for the watchdog reset/wakeup block
// Assumes: one 125 MHz clock, watchdog tick supplied as a one-cycle enable
// Notes:   control word layout follows the control register bit positions
package wdg_pkg;

	// ==========================================================
	// control word field positions
	localparam int CLR_BIT     = 0;   // counter clear request
	localparam int WAKE_EN_BIT = 4;   // wakeup enable
	localparam int IRQ_EN_BIT  = 6;   // expiry interrupt enable
	localparam int RUN_BIT     = 7;   // run enable
	localparam int SEL_LO      = 8;   // interval select low bit
	localparam int SEL_HI      = 10;  // interval select high bit

	// ==========================================================
	// widths, reset values and timing counts
	localparam int CNT_W = 19;        // one spare bit so 2^18 is reachable
	localparam logic [2:0] SEL_RESET = 3'h7;          // interval select after reset
	localparam logic [10:0] GRACE_TICKS = 11'h400;    // 1024 watchdog clocks
	localparam logic [5:0] RST_TICKS = 6'h3f;         // 63 watchdog clocks

	// ==========================================================
	// unlock byte sequence
	localparam logic [7:0] KEY0 = 8'h59;
	localparam logic [7:0] KEY1 = 8'h16;
	localparam logic [7:0] KEY2 = 8'h88;

	// ==========================================================
	// software write carrier
	typedef struct packed {
		logic       run_en;       // wdg_run_enable
		logic       irq_en;       // expiry_irq_enable
		logic       wake_en;      // wakeup enable
		logic [2:0] interval_sel; // interval_select
	} ctrl_type;

	// watchdog state, one-hot
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_COUNT = 4'b0010,
		ST_GRACE = 4'b0100,
		ST_RESET = 4'b1000
	} state_type;

endpackage : wdg_pkg

/* hdl/wdg_unlock.sv */
// Purpose: write protection key detector for the watchdog control bits
// Assumes: key bytes arrive as one-cycle strobes
// Notes:   any wrong byte restarts the key sequence without relocking; lock_req relocks
`timescale 1ns/1ps
`default_nettype none
module wdg_unlock
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       srst,
	// key port
	input  wire logic       key_we,
	input  wire logic [7:0] key_data,
	input  wire logic       lock_req,
	// status
	output logic            unlocked
);
	import wdg_pkg::*;

	logic [1:0] step_reg; // how many key bytes matched so far

	// ==========================================================
	// key sequence tracking
	always_ff @(posedge clock)
	begin
		if (srst || lock_req)
		begin
			step_reg <= 2'h0;
			unlocked <= 1'b0;
		end
		else if (key_we)
		begin
			// a wrong byte restarts the sequence, it does not relock
			if (step_reg == 2'h0 && key_data == KEY0)
				step_reg <= 2'h1;
			else if (step_reg == 2'h1 && key_data == KEY1)
				step_reg <= 2'h2;
			else if (step_reg == 2'h2 && key_data == KEY2)
			begin
				step_reg <= 2'h0;
				unlocked <= 1'b1;
			end
			else
				step_reg <= 2'h0;
		end
	end

endmodule : wdg_unlock
`default_nettype wire

/* hdl/wdg_reset_wakeup.sv */
// Purpose: watchdog with expiry flag, grace delay, cpu reset and wakeup
// Assumes: wdg_tick is a one-cycle enable at the watchdog clock rate
// Notes:   reset flag is cleared only by the chip-level srst
`timescale 1ns/1ps
`default_nettype none
module wdg_reset_wakeup
(
	// clock and reset
	input  wire logic             clock,
	input  wire logic             srst,
	// watchdog clock enable
	input  wire logic             wdg_tick,
	// protection key port
	input  wire logic             key_we,
	input  wire logic [7:0]       key_data,
	input  wire logic             lock_req,
	// control writes
	input  wire logic             ctrl_we,
	input  wire wdg_pkg::ctrl_type ctrl_wdata,
	input  wire logic             clear_req_set,
	input  wire logic             expiry_flag_w1c,
	// chip state
	input  wire logic             powered_down,
	// status and control readback
	output logic [10:0]           wdg_control_word,
	output logic                  unlocked,
	output logic                  expiry_flag,
	output logic                  wdg_reset_flag,
	// actions
	output logic                  irq,
	output logic                  cpu_reset,
	output logic                  wakeup
);
	import wdg_pkg::*;

	// ==========================================================
	// state
	state_type         state_reg;      // watchdog sequencing
	ctrl_type          ctrl_reg;       // protected control bits
	logic              clear_req_reg;  // counter_clear_request
	logic [CNT_W-1:0]  count_reg;      // tick counter, holds at limit - 1
	logic [10:0]       grace_reg;      // grace delay ticks elapsed
	logic [5:0]        rst_cnt_reg;    // cpu reset length counter
	logic [CNT_W-1:0]  limit;          // selected timeout in ticks
	logic              hit;            // counter at interval this tick
	logic              grace_done;     // grace delay expires this tick
	logic              unlocked_w;     // key detector result

	// ==========================================================
	// write protection
	wdg_unlock wdg_unlock_inst
	(
		.clock    (clock),
		.srst     (srst),
		.key_we   (key_we),
		.key_data (key_data),
		.lock_req (lock_req),
		.unlocked (unlocked_w)
	);

	// interval decode: 2^(4 + 2*code)
	always_comb
	begin
		limit = CNT_W'(1) << (5'd4 + {1'b0, ctrl_reg.interval_sel, 1'b0});
	end

	// a shorter interval written mid-count expires at once instead of wrapping the counter
	assign hit        = wdg_tick && ctrl_reg.run_en && state_reg == ST_COUNT && count_reg >= limit - CNT_W'(1);
	assign grace_done = wdg_tick && state_reg == ST_GRACE && grace_reg == GRACE_TICKS - 11'h1;

	// ==========================================================
	// protected control bits, writes ignored while locked
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			ctrl_reg <= '{run_en: 1'b0, irq_en: 1'b0, wake_en: 1'b0, interval_sel: SEL_RESET};
		end
		else if (ctrl_we && unlocked_w)
			ctrl_reg <= ctrl_wdata;
	end

	// clear request bit, drops once the counter is zeroed
	always_ff @(posedge clock)
	begin
		if (srst)
			clear_req_reg <= 1'b0;
		else if (clear_req_set && unlocked_w)
			clear_req_reg <= 1'b1;
		else if (clear_req_reg)
			clear_req_reg <= 1'b0;
	end

	// ==========================================================
	// sequencing state machine
	always_ff @(posedge clock)
	begin
		if (srst)
			state_reg <= ST_IDLE;
		else
		begin
			unique case (state_reg)
				ST_IDLE:
					if (ctrl_reg.run_en)
						state_reg <= ST_COUNT;
				ST_COUNT:
					if (!ctrl_reg.run_en)
						state_reg <= ST_IDLE;
					else if (hit)
						state_reg <= ST_GRACE;
				ST_GRACE:
					// clear or disable wins over expiry
					if (!ctrl_reg.run_en)
						state_reg <= ST_IDLE;
					else if (clear_req_reg)
						state_reg <= ST_COUNT;
					else if (grace_done)
						state_reg <= powered_down ? ST_COUNT : ST_RESET;
				ST_RESET:
					// reset ends after 63 ticks; watchdog restarts from zero
					if (wdg_tick && rst_cnt_reg == RST_TICKS - 6'h1)
						state_reg <= ST_COUNT;
			endcase
		end
	end

	// counter, zeroed by clear, disable, grace expiry or cpu reset
	// grace expiry zeroes it too, so a wakeup restarts the full interval
	always_ff @(posedge clock)
	begin
		if (srst || clear_req_reg || !ctrl_reg.run_en || state_reg == ST_RESET || grace_done)
			count_reg <= '0;
		else if (wdg_tick && state_reg != ST_IDLE && count_reg < limit - CNT_W'(1))
			count_reg <= count_reg + CNT_W'(1);
	end

	// grace delay counter
	always_ff @(posedge clock)
	begin
		if (srst || state_reg != ST_GRACE)
			grace_reg <= 11'h0;
		else if (wdg_tick)
			grace_reg <= grace_reg + 11'h1;
	end

	// cpu reset length counter
	always_ff @(posedge clock)
	begin
		if (srst || state_reg != ST_RESET)
			rst_cnt_reg <= 6'h0;
		else if (wdg_tick)
			rst_cnt_reg <= rst_cnt_reg + 6'h1;
	end

	// ==========================================================
	// flags: hardware set wins over software clear
	always_ff @(posedge clock)
	begin
		if (srst)
			expiry_flag <= 1'b0;
		else if (hit)
			expiry_flag <= 1'b1;
		else if (expiry_flag_w1c)
			expiry_flag <= 1'b0;
	end

	// the cpu reset output does not touch this flag, only srst does
	always_ff @(posedge clock)
	begin
		if (srst)
			wdg_reset_flag <= 1'b0;
		else if (grace_done && !clear_req_reg && ctrl_reg.run_en && !powered_down)
			wdg_reset_flag <= 1'b1;
	end

	// ==========================================================
	// registered outputs
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			irq              <= 1'b0;
			cpu_reset        <= 1'b0;
			wakeup           <= 1'b0;
			unlocked         <= 1'b0;
			wdg_control_word <= 11'h0;
		end
		else
		begin
			irq       <= expiry_flag && ctrl_reg.irq_en;
			cpu_reset <= state_reg == ST_RESET;
			// wakeup is a one-cycle pulse
			wakeup    <= grace_done && !clear_req_reg && ctrl_reg.run_en
			             && powered_down && ctrl_reg.wake_en;
			unlocked  <= unlocked_w;
			wdg_control_word <= {ctrl_reg.interval_sel, ctrl_reg.run_en, ctrl_reg.irq_en, 1'b0,
			                     ctrl_reg.wake_en, expiry_flag, wdg_reset_flag, 1'b0, clear_req_reg};
		end
	end

	// ==========================================================
	// checks
	sequence s_grace_expiry;
		state_reg == ST_GRACE && grace_done && ctrl_reg.run_en && !clear_req_reg;
	endsequence

	a_reset_entry: assert property (@(posedge clock) disable iff (srst)
		s_grace_expiry and !powered_down |=> state_reg == ST_RESET ##1 cpu_reset && wdg_reset_flag)
		else $error("grace expiry did not reset cpu");
	a_wake_pulse: assert property (@(posedge clock) disable iff (srst)
		s_grace_expiry and powered_down && ctrl_reg.wake_en |=> wakeup)
		else $error("no wakeup after grace expiry");
	a_wake_restart: assert property (@(posedge clock) disable iff (srst)
		s_grace_expiry and powered_down |=> state_reg == ST_COUNT && count_reg == '0 && !cpu_reset)
		else $error("no counter restart after wakeup");
	a_flag_sticky: assert property (@(posedge clock) disable iff (srst)
		wdg_reset_flag |=> wdg_reset_flag)
		else $error("reset flag dropped");
	a_expiry_set: assert property (@(posedge clock) disable iff (srst)
		hit |=> expiry_flag && state_reg == ST_GRACE)
		else $error("expiry flag not set on timeout");
	a_expiry_hold: assert property (@(posedge clock) disable iff (srst)
		expiry_flag && !expiry_flag_w1c |=> expiry_flag)
		else $error("expiry flag lost");
	a_clear_zero: assert property (@(posedge clock) disable iff (srst)
		clear_req_reg |=> count_reg == '0 && !clear_req_reg)
		else $error("clear request did not zero counter");
	a_stop_zero: assert property (@(posedge clock) disable iff (srst)
		!ctrl_reg.run_en |=> count_reg == '0)
		else $error("counter not zeroed while stopped");
	a_locked_write: assert property (@(posedge clock) disable iff (srst)
		ctrl_we && !unlocked_w |=> $stable(ctrl_reg))
		else $error("locked write changed control");
	a_reset_len: assert property (@(posedge clock) disable iff (srst)
		state_reg == ST_RESET |-> rst_cnt_reg < RST_TICKS)
		else $error("cpu reset too long");
	a_grace_len: assert property (@(posedge clock) disable iff (srst)
		state_reg == ST_GRACE |-> grace_reg < GRACE_TICKS)
		else $error("grace delay too long");

endmodule : wdg_reset_wakeup
`default_nettype wire

/* dv/wdg_reset_wakeup_bench.sv */
// Purpose: self-checking bench for the watchdog reset/wakeup block
// Assumes: wdg_tick held high except in the half-rate test, so one watchdog clock per system clock
// Notes:   windows allow a few cycles of pipeline latency
`timescale 1ns/1ps
`default_nettype none
module wdg_reset_wakeup_bench;
	import wdg_pkg::*;
	// ==========================================================
	// stimulus and observed signals
	logic        clock, srst, wdg_tick, key_we, lock_req, ctrl_we;
	logic        clear_req_set, expiry_flag_w1c, powered_down;
	logic        tick_half;   // slows the watchdog tick to every other cycle
	logic [7:0]  key_data;
	ctrl_type    ctrl_wdata;
	logic [10:0] wdg_control_word;
	logic        unlocked, expiry_flag, wdg_reset_flag, irq, cpu_reset, wakeup;
	int          failures, checked, cycles, n, lim;
	wdg_reset_wakeup wdg_reset_wakeup_inst (.clock(clock), .srst(srst), .wdg_tick(wdg_tick),
		.key_we(key_we), .key_data(key_data), .lock_req(lock_req), .ctrl_we(ctrl_we),
		.ctrl_wdata(ctrl_wdata), .clear_req_set(clear_req_set), .expiry_flag_w1c(expiry_flag_w1c),
		.powered_down(powered_down), .wdg_control_word(wdg_control_word), .unlocked(unlocked),
		.expiry_flag(expiry_flag), .wdg_reset_flag(wdg_reset_flag), .irq(irq),
		.cpu_reset(cpu_reset), .wakeup(wakeup));
	// ==========================================================
	// clock and hang guard
	always #4 clock = ~clock;
	// watchdog tick: every cycle, or every other cycle while tick_half is set
	always @(posedge clock)
		wdg_tick <= !tick_half || !wdg_tick;
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			failures++;
			give_verdict();
		end
	end
	// ==========================================================
	// helper tasks
	task automatic give_verdict();
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one-cycle strobes: 1 clear, 2 flag clear, 3 relock
	task automatic pulse(input int k);
		@(posedge clock);
		case (k)
			1: clear_req_set <= 1'b1;
			2: expiry_flag_w1c <= 1'b1;
			default: lock_req <= 1'b1;
		endcase
		@(posedge clock);
		{clear_req_set, expiry_flag_w1c, lock_req} <= 3'h0;
	endtask : pulse
	task automatic set_ctrl(input logic r, input logic i, input logic w, input logic [2:0] s);
		@(posedge clock);
		ctrl_wdata <= {r, i, w, s};
		ctrl_we    <= 1'b1;
		@(posedge clock);
		ctrl_we <= 1'b0;
	endtask : set_ctrl
	// key bytes back to back, strobe held across them
	task automatic unlock();
		logic [7:0] keys [3];
		keys = '{KEY0, KEY1, KEY2};
		foreach (keys[i])
		begin
			@(posedge clock);
			key_we   <= 1'b1;
			key_data <= keys[i];
		end
		@(posedge clock);
		key_we <= 1'b0;
	endtask : unlock
	function automatic logic pick(input int k);
		case (k)
			0: return expiry_flag;
			1: return cpu_reset;
			2: return wakeup;
			3: return unlocked;
			default: return !cpu_reset;
		endcase
	endfunction : pick
	// bounded wait, n holds the cycles taken
	task automatic wait_sig(input int k, input int max);
		n = 0;
		do
		begin
			@(posedge clock);
			#1;
			n++;
		end
		while (pick(k) !== 1'b1 && n < max);
	endtask : wait_sig
	// ==========================================================
	// main sequence
	initial
	begin
		{clock, key_we, lock_req, ctrl_we, clear_req_set, expiry_flag_w1c, powered_down} = 7'h0;
		srst = 1'b1;
		tick_half = 1'b0;
		key_data = 8'h00;
		ctrl_wdata = 6'h00;
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		repeat (2) @(posedge clock);
		#1 check(wdg_control_word, 11'h700);
		// locked write refused, idle means no counting
		set_ctrl(1'b1, 1'b1, 1'b0, 3'h0);
		repeat (40) @(posedge clock);
		#1 check(wdg_control_word, 11'h700);
		check(expiry_flag, 1'b0);
		unlock();
		wait_sig(3, 4);
		check(unlocked, 1'b1);
		// interrupt enabled expiry, then cleared inside grace
		set_ctrl(1'b1, 1'b1, 1'b0, 3'h0);
		wait_sig(0, 30);
		check(n >= 15 && n <= 19, 1'b1);
		wait_sig(3, 1);
		check(irq, 1'b1);
		check(wdg_control_word[10:3], 8'h19);
		repeat (500) @(posedge clock);
		pulse(1);
		pulse(2);
		#1 check(wdg_control_word[0], 1'b0);
		check(expiry_flag, 1'b0);
		wait_sig(1, 600);
		check(cpu_reset, 1'b0);
		// interval codes 0 to 5, interrupt off
		for (int s = 0; s < 6; s++)
		begin
			lim = 1 << (4 + 2 * s);
			set_ctrl(1'b0, 1'b0, 1'b0, s[2:0]);
			pulse(2);
			#1 check(expiry_flag, 1'b0);
			set_ctrl(1'b1, 1'b0, 1'b0, s[2:0]);
			wait_sig(0, lim + 10);
			check(n >= lim - 1 && n <= lim + 3, 1'b1);
			wait_sig(3, 1);
			check(irq, 1'b0);
		end
		// half-rate watchdog tick doubles the shortest interval
		@(posedge clock);
		tick_half <= 1'b1;
		set_ctrl(1'b0, 1'b0, 1'b0, 3'h0);
		pulse(2);
		set_ctrl(1'b1, 1'b0, 1'b0, 3'h0);
		wait_sig(0, 60);
		check(n >= 30 && n <= 36, 1'b1);
		@(posedge clock);
		tick_half <= 1'b0;
		// no clear: grace, cpu reset, sticky flag
		set_ctrl(1'b0, 1'b0, 1'b0, 3'h0);
		pulse(2);
		set_ctrl(1'b1, 1'b0, 1'b0, 3'h0);
		wait_sig(0, 30);
		wait_sig(1, 1100);
		check(n >= 1022 && n <= 1026, 1'b1);
		check(wdg_reset_flag, 1'b1);
		wait_sig(4, 100);
		check(n, 63);
		check(wdg_reset_flag, 1'b1);
		// powered down: wakeup instead of cpu reset
		@(posedge clock);
		powered_down <= 1'b1;
		set_ctrl(1'b0, 1'b0, 1'b0, 3'h0);
		pulse(2);
		set_ctrl(1'b1, 1'b0, 1'b1, 3'h0);
		wait_sig(0, 30);
		wait_sig(2, 1100);
		check(wakeup, 1'b1);
		check(cpu_reset, 1'b0);
		// relock, then a refused write
		pulse(3);
		set_ctrl(1'b0, 1'b0, 1'b0, 3'h5);
		repeat (2) @(posedge clock);
		#1 check(wdg_control_word[10:7], 4'h1);
		check(unlocked, 1'b0);
		// chip reset clears the sticky flag
		@(posedge clock);
		srst <= 1'b1;
		@(posedge clock);
		srst <= 1'b0;
		repeat (2) @(posedge clock);
		#1 check({wdg_reset_flag, wdg_control_word}, 12'h700);
		give_verdict();
	end
endmodule : wdg_reset_wakeup_bench
`default_nettype wire
